/* File: rtl/tscfg_pkg.sv */
// shared constants and carriers for the touch sensing configuration registers
package tscfg_pkg;
    // register byte addresses, reset value and unmapped read value
    localparam logic [7:0] ADDR_REPORT   = 8'h71;
    localparam logic [7:0] ADDR_CHEN0    = 8'h72;
    localparam logic [7:0] ADDR_CHEN1    = 8'h73;
    localparam logic [7:0] ADDR_CHEN2    = 8'h74;
    localparam logic [7:0] ADDR_CALPER   = 8'h76;
    localparam logic [7:0] ADDR_CALMOD   = 8'h77;
    localparam logic [7:0] ADDR_FILTER   = 8'h78;
    localparam logic [7:0] ADDR_SELECT   = 8'h7C;
    localparam logic [7:0] ADDR_WIN_LO   = 8'hC0;
    localparam logic [7:0] ADDR_WIN_HI   = 8'hEF;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    localparam logic [7:0] READ_ZERO     = 8'h00;

    localparam int NUM_CH = 24;

    // data selector codes
    localparam logic [7:0] SEL_TOUCH  = 8'h01;
    localparam logic [7:0] SEL_ENV    = 8'h02;
    localparam logic [7:0] SEL_DELAY  = 8'h03;
    localparam logic [7:0] SEL_LIVE   = 8'h04;
    localparam logic [7:0] SEL_CALIB  = 8'h05;
    localparam logic [7:0] SEL_LOCKED = 8'h06;

    // calibration algorithm codes
    localparam logic [1:0] ALG_PLAIN    = 2'h0;
    localparam logic [1:0] ALG_AUTOTUNE = 2'h2;

    // calibration period multipliers
    localparam logic [9:0] MULT_0 = 10'h008;
    localparam logic [9:0] MULT_1 = 10'h020;
    localparam logic [9:0] MULT_2 = 10'h080;
    localparam logic [9:0] MULT_3 = 10'h200;

    // filter sample sets: collect / discard
    localparam logic [4:0] SET0_COLLECT = 5'h0A;
    localparam logic [2:0] SET0_DISCARD = 3'h2;
    localparam logic [4:0] SET1_COLLECT = 5'h12;
    localparam logic [2:0] SET1_DISCARD = 3'h2;
    localparam logic [4:0] SET2_COLLECT = 5'h14;
    localparam logic [2:0] SET2_DISCARD = 3'h4;

    localparam logic [3:0] CAL_SAMPLES = 4'h8;

    // time base
    localparam int CLOCK_NS    = 100;
    localparam int TICK_MS     = 10;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLOCK_NS;

    typedef struct packed {
        logic       valid;
        logic [7:0] pos;
    } tscfg_slider_t;

    typedef struct packed {
        logic [NUM_CH-1:0][8:0]  touch;
        logic [NUM_CH-1:0][8:0]  env;
        logic [NUM_CH-1:0][5:0]  delay;
        logic [NUM_CH-1:0][12:0] live;
        logic [NUM_CH-1:0][12:0] calib;
    } tscfg_chan_t;

    typedef struct packed {
        logic       stb;
        logic [7:0] kind;
        logic [4:0] idx;
        logic       high;
        logic [7:0] data;
    } tscfg_chwr_t;

    typedef struct packed {
        logic       on;
        logic [4:0] collect;
        logic [2:0] discard;
    } tscfg_filter_t;
endpackage

/* File: rtl/tscfg_regs.sv */
// touch sensing configuration register bank with channel data window
// Functional notes
// - upper nibble caps suppressed slider reports
// - lower nibble is minimum position change
// - three bytes hold 24 channel enables
// - multiplier codes give 8, 32, 128, 512
// - calibration every interval times 10ms times multiplier
// - sample spacing is field times 10ms
// - algorithm code 00 plain, 10 autotune
// - autotune retunes itself, blocks delay access
// - bit 0 enables periodic calibration
// - filter mode picks 10/2, 18/2, 20/4
// - filter bit 0 switches median filter
// - selector codes choose threshold, delay, impedance
// - channel word low byte at base+2n
// - window returns selector's chosen quantity
// - locked impedance frozen on writing 0x06
`timescale 1ns/1ps
module tscfg_regs #(
    parameter int TICK_CYCLES = tscfg_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                     CLOCK,
    input  wire logic                     ARST_N,
    // register port
    input  wire logic [7:0]               REG_ADDR,
    input  wire logic [7:0]               REG_WDATA,
    input  wire logic                     REG_WR,
    input  wire logic                     REG_RD,
    output logic      [7:0]               REG_RDATA,
    // slider reports
    input  wire tscfg_pkg::tscfg_slider_t SLIDER_IN,
    output tscfg_pkg::tscfg_slider_t      REPORT_OUT,
    // channel data from and writes to the front end
    input  wire tscfg_pkg::tscfg_chan_t   CHAN_IN,
    input  wire logic [23:0]              OUT_OF_RANGE,
    output tscfg_pkg::tscfg_chwr_t        CHAN_WR,
    // control toward the front end
    output logic      [23:0]              CHAN_ENABLE,
    output logic                          AUTO_TUNE,
    output logic      [23:0]              RETUNE,
    output logic                          CAL_START,
    output logic                          CAL_SAMPLE,
    output tscfg_pkg::tscfg_filter_t      FILTER_CFG
);
    logic [1:0]  rst_sync_q;
    logic        rst_n;
    logic [7:0]  report_q, calper_q, calmod_q, filter_q, select_q;
    logic [23:0] chen_q;
    logic [12:0] locked_q [tscfg_pkg::NUM_CH];
    logic        win_hit;
    logic [4:0]  win_idx;
    logic [7:0]  win_off;
    logic        autotune;
    logic        delay_blocked;
    logic [15:0] win_word;

    // reset release through two flops
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    assign win_hit = (REG_ADDR >= tscfg_pkg::ADDR_WIN_LO) && (REG_ADDR <= tscfg_pkg::ADDR_WIN_HI);
    assign win_off = REG_ADDR - tscfg_pkg::ADDR_WIN_LO;
    assign win_idx = win_off[5:1];
    assign autotune = (calmod_q[2:1] == tscfg_pkg::ALG_AUTOTUNE);
    assign delay_blocked = autotune && (select_q == tscfg_pkg::SEL_DELAY);

    // plain configuration registers
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            report_q <= tscfg_pkg::RESET_BYTE;
            calper_q <= tscfg_pkg::RESET_BYTE;
            calmod_q <= tscfg_pkg::RESET_BYTE;
            filter_q <= tscfg_pkg::RESET_BYTE;
            select_q <= tscfg_pkg::RESET_BYTE;
            chen_q   <= 24'h000000;
        end
        else if (REG_WR)
        begin
            case (REG_ADDR)
                tscfg_pkg::ADDR_REPORT: report_q      <= REG_WDATA;
                tscfg_pkg::ADDR_CHEN0:  chen_q[7:0]   <= REG_WDATA;
                tscfg_pkg::ADDR_CHEN1:  chen_q[15:8]  <= REG_WDATA;
                tscfg_pkg::ADDR_CHEN2:  chen_q[23:16] <= REG_WDATA;
                tscfg_pkg::ADDR_CALPER: calper_q      <= REG_WDATA;
                tscfg_pkg::ADDR_CALMOD: calmod_q      <= REG_WDATA;
                tscfg_pkg::ADDR_FILTER: filter_q      <= REG_WDATA;
                tscfg_pkg::ADDR_SELECT: select_q      <= REG_WDATA;
                default:                ;
            endcase
        end
    end

    assign CHAN_ENABLE = chen_q;
    assign AUTO_TUNE   = autotune;

    // locked impedance snapshot, one entry per channel
    genvar g;
    generate
        for (g = 0; g < tscfg_pkg::NUM_CH; g++)
        begin : g_ch
            always_ff @(posedge CLOCK or negedge rst_n)
            begin
                if (!rst_n)
                    locked_q[g] <= 13'h0000;
                else if (REG_WR && REG_ADDR == tscfg_pkg::ADDR_SELECT
                         && REG_WDATA == tscfg_pkg::SEL_LOCKED
                         && select_q != tscfg_pkg::SEL_LOCKED)
                    locked_q[g] <= CHAN_IN.live[g];
            end
            assign RETUNE[g] = autotune && chen_q[g] && OUT_OF_RANGE[g];
        end
    endgenerate

    // word chosen by the selector for one channel
    function automatic logic [15:0] chan_word(input logic [4:0] idx);
        logic [15:0] w;
        w = 16'h0000;
        case (select_q)
            tscfg_pkg::SEL_TOUCH:  w = {7'h00, CHAN_IN.touch[idx]};
            tscfg_pkg::SEL_ENV:    w = {7'h00, CHAN_IN.env[idx]};
            tscfg_pkg::SEL_DELAY:  w = delay_blocked ? 16'h0000 : {10'h000, CHAN_IN.delay[idx]};
            tscfg_pkg::SEL_LIVE:   w = {3'h0, CHAN_IN.live[idx]};
            tscfg_pkg::SEL_CALIB:  w = {3'h0, CHAN_IN.calib[idx]};
            tscfg_pkg::SEL_LOCKED: w = {3'h0, locked_q[idx]};
            default:               w = 16'h0000;
        endcase
        return w;
    endfunction

    // selected word of the addressed channel
    always_comb
        win_word = chan_word(win_idx);

    // read data, captured on the read strobe
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            REG_RDATA <= tscfg_pkg::READ_ZERO;
        else if (REG_RD)
        begin
            if (win_hit)
                REG_RDATA <= win_off[0] ? win_word[15:8] : win_word[7:0];
            else
            begin
                case (REG_ADDR)
                    tscfg_pkg::ADDR_REPORT: REG_RDATA <= report_q;
                    tscfg_pkg::ADDR_CHEN0:  REG_RDATA <= chen_q[7:0];
                    tscfg_pkg::ADDR_CHEN1:  REG_RDATA <= chen_q[15:8];
                    tscfg_pkg::ADDR_CHEN2:  REG_RDATA <= chen_q[23:16];
                    tscfg_pkg::ADDR_CALPER: REG_RDATA <= calper_q;
                    tscfg_pkg::ADDR_CALMOD: REG_RDATA <= calmod_q;
                    tscfg_pkg::ADDR_FILTER: REG_RDATA <= filter_q;
                    tscfg_pkg::ADDR_SELECT: REG_RDATA <= select_q;
                    default:                REG_RDATA <= tscfg_pkg::READ_ZERO;
                endcase
            end
        end
    end

    // window writes of thresholds, and of delay outside autotune, pass to the front end
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            CHAN_WR <= '0;
        else
        begin
            CHAN_WR.stb  <= REG_WR && win_hit && !delay_blocked
                            && (select_q == tscfg_pkg::SEL_TOUCH
                                || select_q == tscfg_pkg::SEL_ENV
                                || select_q == tscfg_pkg::SEL_DELAY);
            CHAN_WR.kind <= select_q;
            CHAN_WR.idx  <= win_idx;
            CHAN_WR.high <= win_off[0];
            CHAN_WR.data <= REG_WDATA;
        end
    end

    // filter setup
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            FILTER_CFG <= '0;
        else
        begin
            FILTER_CFG.on <= filter_q[0];
            case (filter_q[2:1])
                2'h1:
                begin
                    FILTER_CFG.collect <= tscfg_pkg::SET1_COLLECT;
                    FILTER_CFG.discard <= tscfg_pkg::SET1_DISCARD;
                end
                2'h2:
                begin
                    FILTER_CFG.collect <= tscfg_pkg::SET2_COLLECT;
                    FILTER_CFG.discard <= tscfg_pkg::SET2_DISCARD;
                end
                default:
                begin
                    FILTER_CFG.collect <= tscfg_pkg::SET0_COLLECT;
                    FILTER_CFG.discard <= tscfg_pkg::SET0_DISCARD;
                end
            endcase
        end
    end

    // 10 ms time base
    logic [16:0] tick_cnt_q;
    logic        tick;
    assign tick = (tick_cnt_q == 17'(TICK_CYCLES - 1));
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            tick_cnt_q <= 17'h00000;
        else
            tick_cnt_q <= tick ? 17'h00000 : tick_cnt_q + 17'h00001;
    end

    // calibration period
    logic [9:0]  mult;
    logic [15:0] period;
    logic [15:0] per_cnt_q;
    logic        cal_en;
    always_comb
    begin
        case (calper_q[7:6])
            2'h0:    mult = tscfg_pkg::MULT_0;
            2'h1:    mult = tscfg_pkg::MULT_1;
            2'h2:    mult = tscfg_pkg::MULT_2;
            default: mult = tscfg_pkg::MULT_3;
        endcase
    end
    assign period = 16'({10'h000, calper_q[5:0]} * mult);
    assign cal_en = calmod_q[0] && (period != 16'h0000);

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            per_cnt_q <= 16'h0000;
            CAL_START <= 1'b0;
        end
        else
        begin
            CAL_START <= 1'b0;
            if (!cal_en)
                per_cnt_q <= 16'h0000;
            else if (tick)
            begin
                if (per_cnt_q + 16'h0001 >= period)
                begin
                    per_cnt_q <= 16'h0000;
                    CAL_START <= 1'b1;
                end
                else
                    per_cnt_q <= per_cnt_q + 16'h0001;
            end
        end
    end

    // eight samples per calibration unit, spaced by calmod_q[7:3] tick pulses, back to back when that field is zero
    logic [3:0] left_q;
    logic [4:0] space_q;
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_q     <= 4'h0;
            space_q    <= 5'h00;
            CAL_SAMPLE <= 1'b0;
        end
        else
        begin
            CAL_SAMPLE <= 1'b0;
            if (CAL_START)
            begin
                left_q     <= tscfg_pkg::CAL_SAMPLES - 4'h1;
                space_q    <= 5'h00;
                CAL_SAMPLE <= 1'b1;
            end
            else if (left_q != 4'h0)
            begin
                if (space_q >= calmod_q[7:3])
                begin
                    left_q     <= left_q - 4'h1;
                    space_q    <= 5'h00;
                    CAL_SAMPLE <= 1'b1;
                end
                else if (tick)
                    space_q <= space_q + 5'h01;
            end
        end
    end

    // slider report throttling
    logic [7:0] last_q;
    logic [3:0] drops_q;
    logic [7:0] moved;
    logic       pass;
    assign moved = (SLIDER_IN.pos >= last_q) ? SLIDER_IN.pos - last_q : last_q - SLIDER_IN.pos;
    assign pass = (report_q[3:0] == 4'h0)
               || (moved >= {4'h0, report_q[3:0]})
               || (report_q[7:4] == 4'h0)
               || (drops_q >= report_q[7:4]);
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_q     <= 8'h00;
            drops_q    <= 4'h0;
            REPORT_OUT <= '0;
        end
        else
        begin
            REPORT_OUT.valid <= SLIDER_IN.valid && pass;
            if (SLIDER_IN.valid && pass)
            begin
                REPORT_OUT.pos <= SLIDER_IN.pos;
                last_q         <= SLIDER_IN.pos;
                drops_q        <= 4'h0;
            end
            else if (SLIDER_IN.valid)
                drops_q <= drops_q + 4'h1;
        end
    end

    property p_no_drop_zero;
        @(posedge CLOCK) disable iff (!rst_n)
        SLIDER_IN.valid && report_q[7:4] == 4'h0 |=> REPORT_OUT.valid;
    endproperty
    a_no_drop_zero: assert property (p_no_drop_zero) else $error("report dropped");

    property p_min_zero;
        @(posedge CLOCK) disable iff (!rst_n)
        SLIDER_IN.valid && report_q[3:0] == 4'h0 |=> REPORT_OUT.valid && REPORT_OUT.pos == $past(SLIDER_IN.pos);
    endproperty
    a_min_zero: assert property (p_min_zero) else $error("sample not reported");

    property p_chen_byte;
        @(posedge CLOCK) disable iff (!rst_n)
        REG_WR && REG_ADDR == tscfg_pkg::ADDR_CHEN1 |=> CHAN_ENABLE[15:8] == $past(REG_WDATA);
    endproperty
    a_chen_byte: assert property (p_chen_byte) else $error("enable byte wrong");

    property p_mult_max;
        @(posedge CLOCK) disable iff (!rst_n)
        calper_q[7:6] == 2'h3 |-> period == {calper_q[5:0], 9'h000};
    endproperty
    a_mult_max: assert property (p_mult_max) else $error("multiplier wrong");

    property p_start_gap;
        @(posedge CLOCK) disable iff (!rst_n)
        CAL_START |=> !CAL_START [*8];
    endproperty
    a_start_gap: assert property (p_start_gap) else $error("calibration too often");

    property p_start_en;
        @(posedge CLOCK) disable iff (!rst_n)
        CAL_START |-> $past(calmod_q[0]);
    endproperty
    a_start_en: assert property (p_start_en) else $error("calibration while disabled");

    property p_spacing;
        @(posedge CLOCK) disable iff (!rst_n)
        CAL_SAMPLE && calmod_q[7:3] != 5'h00 |=> !CAL_SAMPLE;
    endproperty
    a_spacing: assert property (p_spacing) else $error("samples too close");

    property p_retune;
        @(posedge CLOCK) disable iff (!rst_n)
        RETUNE != 24'h000000 |-> calmod_q[2:1] == tscfg_pkg::ALG_AUTOTUNE;
    endproperty
    a_retune: assert property (p_retune) else $error("retune outside autotune");

    property p_set18;
        @(posedge CLOCK) disable iff (!rst_n)
        filter_q[2:1] == 2'h1 |=> FILTER_CFG.collect == 5'h12 && FILTER_CFG.discard == 3'h2;
    endproperty
    a_set18: assert property (p_set18) else $error("filter set wrong");

    property p_sel_read;
        @(posedge CLOCK) disable iff (!rst_n)
        REG_RD && REG_ADDR == tscfg_pkg::ADDR_SELECT && !REG_WR |=> REG_RDATA == select_q;
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("selector readback");

    property p_live_word;
        @(posedge CLOCK) disable iff (!rst_n)
        REG_RD && REG_ADDR == tscfg_pkg::ADDR_WIN_LO && select_q == tscfg_pkg::SEL_LIVE
        |=> REG_RDATA == $past(CHAN_IN.live[0][7:0]);
    endproperty
    a_live_word: assert property (p_live_word) else $error("window content");

    property p_locked_hold;
        @(posedge CLOCK) disable iff (!rst_n)
        select_q == tscfg_pkg::SEL_LOCKED && $stable(select_q) |-> $stable(locked_q[0]);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("locked data moved");
endmodule

/* File: verification/test_tscfg_regs.sv */
// self-checking bench for the touch sensing configuration registers
`timescale 1ns/1ps
module test_tscfg_regs;
    logic                     clock;
    logic                     arst_n;
    logic [7:0]               reg_addr;
    logic [7:0]               reg_wdata;
    logic                     reg_wr;
    logic                     reg_rd;
    logic [7:0]               reg_rdata;
    tscfg_pkg::tscfg_slider_t slider;
    tscfg_pkg::tscfg_slider_t report;
    tscfg_pkg::tscfg_chan_t   chan;
    logic [23:0]              oor;
    tscfg_pkg::tscfg_chwr_t   chwr;
    logic [23:0]              chen;
    logic                     auto_tune;
    logic [23:0]              retune;
    logic                     cal_start;
    logic                     cal_sample;
    tscfg_pkg::tscfg_filter_t filt;
    logic [12:0]              locked [24];
    logic [7:0]               last_pos;
    int                       drops;
    int                       failures = 0;
    int                       n_checks = 0;
    int                       cycles = 0;

    tscfg_regs #(.TICK_CYCLES(10)) dut_u (
        .CLOCK(clock), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .SLIDER_IN(slider),
        .REPORT_OUT(report), .CHAN_IN(chan), .OUT_OF_RANGE(oor), .CHAN_WR(chwr),
        .CHAN_ENABLE(chen), .AUTO_TUNE(auto_tune), .RETUNE(retune), .CAL_START(cal_start),
        .CAL_SAMPLE(cal_sample), .FILTER_CFG(filt)
    );

    tscfg_host_model host_u (
        .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    initial clock = 1'b0;
    always #50 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            print_verdict();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        chk_reg(32'(got), 32'(exp));
    endtask

    task automatic print_verdict();
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [15:0] exp_word(input logic [7:0] sel, input int ch, input logic at);
        case (sel)
            tscfg_pkg::SEL_TOUCH:  return {7'h00, chan.touch[ch]};
            tscfg_pkg::SEL_ENV:    return {7'h00, chan.env[ch]};
            tscfg_pkg::SEL_DELAY:  return at ? 16'h0000 : {10'h000, chan.delay[ch]};
            tscfg_pkg::SEL_LIVE:   return {3'h0, chan.live[ch]};
            tscfg_pkg::SEL_CALIB:  return {3'h0, chan.calib[ch]};
            tscfg_pkg::SEL_LOCKED: return {3'h0, locked[ch]};
            default:               return 16'h0000;
        endcase
    endfunction

    task automatic rd_word(input int ch, output logic [15:0] w);
        logic [7:0] lo;
        logic [7:0] hi;
        host_u.rd(tscfg_pkg::ADDR_WIN_LO + 8'(2 * ch), lo);
        host_u.rd(tscfg_pkg::ADDR_WIN_LO + 8'(2 * ch + 1), hi);
        w = {hi, lo};
    endtask

    task automatic fill_chan();
        for (int i = 0; i < 24; i++)
        begin
            chan.touch[i] = 9'($urandom);
            chan.env[i]   = 9'($urandom);
            chan.delay[i] = 6'($urandom);
            chan.live[i]  = 13'($urandom);
            chan.calib[i] = 13'($urandom);
        end
    endtask

    // back-to-back slider samples, each checked one cycle after it is taken
    task automatic slide_run(input logic [7:0] cfg, input int n);
        logic exp_v;
        logic [7:0] pos;
        int k;
        exp_v = 1'b0;
        pos = 8'h00;
        host_u.wr(tscfg_pkg::ADDR_REPORT, cfg);
        for (int i = 0; i <= n; i++)
        begin
            @(negedge clock);
            if (i > 0)
                chk_reg({23'h0, report}, {23'h0, exp_v, last_pos});
            k = $urandom % 7;
            pos = (last_pos > 8'hC8) ? last_pos - 8'(k) : last_pos + 8'(k);
            exp_v = cfg[3:0] == 4'h0 || cfg[7:4] == 4'h0 || k >= cfg[3:0] || drops >= cfg[7:4];
            slider.valid = (i < n);
            slider.pos = pos;
            if (i < n && exp_v)
            begin
                last_pos = pos;
                drops = 0;
            end
            else if (i < n)
                drops++;
        end
    endtask

    task automatic cal_period(input logic [7:0] per, input int exp);
        int n;
        int s;
        host_u.wr(tscfg_pkg::ADDR_CALPER, per);
        n = 0;
        while (cal_start !== 1'b1 && n < 2 * exp + 20)
        begin
            @(negedge clock);
            n++;
        end
        n = 0;
        s = 0;
        do
        begin
            @(negedge clock);
            n++;
            s += (cal_sample === 1'b1);
        end while (cal_start !== 1'b1 && n < exp + 20);
        chk_cnt(n, exp);
        chk_cnt(s, 8);
    endtask

    initial
    begin
        logic [7:0] cfg_a [8];
        logic [7:0] val [8];
        logic [7:0] b;
        logic [15:0] w;
        int ch;
        cfg_a = '{8'h71, 8'h72, 8'h73, 8'h74, 8'h76, 8'h77, 8'h78, 8'h7C};
        arst_n = 1'b0;
        slider = '0;
        chan = '0;
        oor = '0;
        last_pos = 8'h00;
        drops = 0;
        b = 8'($urandom(29745));
        repeat (12) @(negedge clock);
        arst_n = 1'b1;
        repeat (3) @(negedge clock);
        for (int i = 0; i < 9; i++)
        begin
            host_u.rd(i < 8 ? cfg_a[i] : tscfg_pkg::ADDR_WIN_LO, b);
            chk_reg({24'h0, b}, 32'h0);
        end
        for (int i = 0; i < 8; i++)
        begin
            val[i] = 8'($urandom);
            host_u.wr(cfg_a[i], val[i]);
        end
        foreach (cfg_a[i])
        begin
            host_u.rd(cfg_a[i], b);
            chk_reg({24'h0, b}, {24'h0, val[i]});
        end
        chk_reg({8'h0, chen}, {8'h0, val[3], val[2], val[1]});
        chk_reg({31'h0, auto_tune}, {31'h0, val[5][2:1] == 2'h2});
        foreach (cfg_a[i])
        begin
            b = (i < 5) ? 8'h70 + 8'(i * 5) : 8'hF0 + 8'(i);
            host_u.wr(b, 8'($urandom));
            host_u.rd(b, b);
            chk_reg({24'h0, b}, 32'h0);
        end
        for (int m = 0; m < 4; m++)
        begin
            b = {5'($urandom), 2'(m), 1'($urandom)};
            host_u.wr(tscfg_pkg::ADDR_FILTER, b);
            @(negedge clock);
            chk_reg({23'h0, filt}, {23'h0, b[0], m == 1 ? tscfg_pkg::SET1_COLLECT : m == 2 ?
                tscfg_pkg::SET2_COLLECT : tscfg_pkg::SET0_COLLECT, m == 2 ?
                tscfg_pkg::SET2_DISCARD : tscfg_pkg::SET0_DISCARD});
        end
        host_u.wr(tscfg_pkg::ADDR_CALMOD, 8'h00);
        fill_chan();
        for (int s = 1; s < 7; s++)
        begin
            host_u.wr(tscfg_pkg::ADDR_SELECT, 8'(s));
            if (s == 6)
                foreach (locked[i]) locked[i] = chan.live[i];
            for (int j = 0; j < 3; j++)
            begin
                ch = (j == 2) ? 0 : j ? 23 : $urandom % 24;
                rd_word(ch, w);
                chk_reg({16'h0, w}, {16'h0, exp_word(8'(s), ch, 1'b0)});
            end
        end
        fill_chan();
        rd_word(23, w);
        chk_reg({16'h0, w}, {19'h0, locked[23]});
        host_u.relock();
        foreach (locked[i]) locked[i] = chan.live[i];
        rd_word(23, w);
        chk_reg({23'h0, host_u.impedance_of(w)}, {23'h0, chan.live[23][12:4]});
        oor = 24'($urandom);
        host_u.wr(tscfg_pkg::ADDR_CALMOD, 8'h04);
        chk_reg({8'h0, retune}, {8'h0, chen & oor});
        host_u.wr(tscfg_pkg::ADDR_SELECT, tscfg_pkg::SEL_DELAY);
        rd_word(5, w);
        chk_reg({16'h0, w}, {16'h0, exp_word(tscfg_pkg::SEL_DELAY, 5, 1'b1)});
        host_u.wr(8'hCA, 8'h3C);
        chk_reg({31'h0, chwr.stb}, 32'h0);
        host_u.wr(tscfg_pkg::ADDR_CALMOD, 8'h00);
        host_u.wr(tscfg_pkg::ADDR_SELECT, tscfg_pkg::SEL_TOUCH);
        b = 8'($urandom);
        host_u.wr(8'hC5, b);
        chk_reg({9'h0, chwr}, {9'h0, 1'b1, 8'h01, 5'h02, 1'b1, b});
        slide_run(8'h00, 1);
        for (int r = 0; r < 6; r++)
            slide_run(r ? 8'($urandom) : 8'h23, 24);
        host_u.wr(tscfg_pkg::ADDR_CALMOD, 8'h09);
        for (int m = 0; m < 4; m++)
            cal_period({2'(m), 6'h01}, 80 << (2 * m));
        host_u.wr(tscfg_pkg::ADDR_CALMOD, 8'h08);
        ch = 0;
        repeat (300)
        begin
            @(negedge clock);
            ch += (cal_start === 1'b1);
        end
        chk_cnt(ch, 0);
        print_verdict();
    end
endmodule

/* File: verification/tscfg_host_model.sv */
// host side model driving the register byte port
`timescale 1ns/1ps
module tscfg_host_model (
    // clock
    input  wire logic       clock,
    // register byte port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // released bus shows the inverse of its last value
    task automatic release_bus();
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    // settings are written with a single-cycle write strobe, whatever the sensor is doing
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        release_bus();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        d = reg_rdata;
        release_bus();
    endtask

    // leave the locked code, then enter it again to refresh
    task automatic relock();
        wr(tscfg_pkg::ADDR_SELECT, 8'h00);
        wr(tscfg_pkg::ADDR_SELECT, tscfg_pkg::SEL_LOCKED);
    endtask

    // usable impedance drops four noise bits
    function automatic logic [8:0] impedance_of(input logic [15:0] w);
        return w[12:4];
    endfunction
endmodule
